// ### verilog/eep_slave.v
// Purpose: serial bus slave front end of a byte EEPROM
// Assumes: bus clock well below sys_clk_i; pins are asynchronous
// Notes:   writes buffered per page, committed after stop
// Notes on behaviour
// - Bus clock strobes data in and out
// - Data line is open drain only
// - Straps compared with select bits b3..b1
// - Floating strap reads as zero
// - Write protect high blocks all writes
// - Protected: ack select/address, nack data
// - Device is slave only
// - Start: data falls while clock high
// - Start watched except during write cycle
// - Stop: data rises while clock high
// - Stop after write begins write cycle
// - Data sampled on rising bus clock
// - Transmitter releases line after eight bits
// - Receiver pulls low on ninth pulse
// - Main array 512 pages of 128 bytes
// - Lockable 128-byte identification page
// - Ack only type 1010b or 1011b
// - Strap mismatch: release bus, standby
// - Select lsb: one read, zero write
// - Two address bytes, msb first, acked
`include "eep_consts.vh"
module eep_slave #(
  parameter WRITE_CYC = `EEP_WRITE_CYC
) (
  input  wire sys_clk_i,
  input  wire rst_i,
  input  wire scl_i,
  input  wire sda_i,
  output wire sda_o,
  output wire sda_oe_o,
  input  wire chip_select_strap_msb,
  input  wire chip_select_strap_mid,
  input  wire chip_select_strap_lsb,
  input  wire write_protect_input,
  output wire busy_o
);
  //----------------------------------------------------------------
  // Phases (one-hot)
  //----------------------------------------------------------------
  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_SEL  = 7'h02;
  localparam [6:0] S_AHI  = 7'h04;
  localparam [6:0] S_ALO  = 7'h08;
  localparam [6:0] S_WDAT = 7'h10;
  localparam [6:0] S_RDAT = 7'h20;
  localparam [6:0] S_PROG = 7'h40;

  //----------------------------------------------------------------
  // Synchronisers
  //----------------------------------------------------------------
  reg [1:0] scl_s_q;
  reg [1:0] sda_s_q;
  reg [1:0] wp_s_q;
  reg [1:0] e2_s_q;
  reg [1:0] e1_s_q;
  reg       scl_p_q;
  reg       sda_p_q;
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
      wp_s_q  <= 2'h0;
      e2_s_q  <= 2'h0;
      e1_s_q  <= 2'h0;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end
    else
    begin
      scl_s_q <= {scl_s_q[0], scl_i};
      sda_s_q <= {sda_s_q[0], sda_i};
      wp_s_q  <= {wp_s_q[0], write_protect_input};
      e2_s_q  <= {e2_s_q[0], chip_select_strap_msb};
      e1_s_q  <= {e1_s_q[0], chip_select_strap_mid};
      scl_p_q <= scl_s_q[1];
      sda_p_q <= sda_s_q[1];
    end
  end
  reg [1:0] e0_s_q;
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      e0_s_q <= 2'h0;
    else
      e0_s_q <= {e0_s_q[0], chip_select_strap_lsb};
  end

  wire scl_w   = scl_s_q[1];
  wire sda_w   = sda_s_q[1];
  wire wp_w    = wp_s_q[1];
  // Floating straps are pulled low at the pad, so they arrive as zero
  wire [2:0] strap_w = {e2_s_q[1], e1_s_q[1], e0_s_q[1]};
  wire scl_rise = scl_w & ~scl_p_q;
  wire scl_fall = ~scl_w & scl_p_q;
  wire start_w  = scl_w & scl_p_q & sda_p_q & ~sda_w;
  wire stop_w   = scl_w & scl_p_q & ~sda_p_q & sda_w;

  //----------------------------------------------------------------
  // Protocol state
  //----------------------------------------------------------------
  reg [6:0]  state_q;
  reg [3:0]  bit_q;
  reg [7:0]  sh_q;
  reg        idpg_q;
  reg        lock_cmd_q;
  reg        locked_q;
  reg [15:0] addr_q;
  reg        ack_q;
  reg        drv_q;
  reg        wr_pend_q;
  reg        wr_any_q;
  reg        mack_q;
  reg [31:0] prog_cnt_q;
  reg [6:0]  prog_idx_q;
  reg        prog_run_q;
  reg [7:0]  pg_buf_q [0:`EEP_PAGE_BYTES-1];
  reg [`EEP_PAGE_BYTES-1:0] pg_vld_q;
  reg [15:0] pg_base_q;

  wire [7:0] main_rd_w;
  wire [7:0] id_rd_w;
  wire       commit_w = prog_run_q & pg_vld_q[prog_idx_q];
  wire [15:0] main_a_w = prog_run_q ? {pg_base_q[15:7], prog_idx_q} : addr_q;
  wire [6:0]  id_a_w   = prog_run_q ? prog_idx_q : addr_q[6:0];

  // 512 pages x 128 bytes
  eep_mem #(.AW(`EEP_MAIN_AW)) u_main (
    .sys_clk_i (sys_clk_i),
    .wr_en_i   (commit_w & ~idpg_q),
    .addr_i    (main_a_w),
    .wr_data_i (pg_buf_q[prog_idx_q]),
    .rd_data_o (main_rd_w)
  );
  eep_mem #(.AW(`EEP_IDPG_AW)) u_idpg (
    .sys_clk_i (sys_clk_i),
    // Lock command only sets the lock bit, page content is kept
    .wr_en_i   (commit_w & idpg_q & ~lock_cmd_q),
    .addr_i    (id_a_w),
    .wr_data_i (pg_buf_q[prog_idx_q]),
    .rd_data_o (id_rd_w)
  );
  wire [7:0] rd_byte_w = (idpg_q & lock_cmd_q) ? {7'h0, locked_q} :
                         (idpg_q ? id_rd_w : main_rd_w);

  wire [7:0] byte_w   = {sh_q[6:0], sda_w};
  wire       sel_ok_w = ((byte_w[7:4] == `EEP_TYPE_MAIN) | (byte_w[7:4] == `EEP_TYPE_IDPG))
                        & (byte_w[3:1] == strap_w);

  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_q    <= S_IDLE;
      bit_q      <= 4'h0;
      sh_q       <= 8'h00;
      idpg_q     <= 1'b0;
      lock_cmd_q <= 1'b0;
      locked_q   <= 1'b0;
      addr_q     <= 16'h0000;
      ack_q      <= 1'b0;
      drv_q      <= 1'b0;
      wr_pend_q  <= 1'b0;
      wr_any_q   <= 1'b0;
      mack_q     <= 1'b0;
      prog_cnt_q <= 32'h0;
      prog_idx_q <= 7'h0;
      prog_run_q <= 1'b0;
      pg_vld_q   <= {`EEP_PAGE_BYTES{1'b0}};
      pg_base_q  <= 16'h0000;
    end
    else if (state_q == S_PROG)
    begin
      // Bus ignored entirely while programming
      drv_q <= 1'b0;
      prog_idx_q <= prog_idx_q + 7'h01;
      if (prog_idx_q == 7'h7f)
        prog_run_q <= 1'b0;
      if (prog_cnt_q == 32'h0)
      begin
        state_q  <= S_IDLE;
        pg_vld_q <= {`EEP_PAGE_BYTES{1'b0}};
      end
      else
        prog_cnt_q <= prog_cnt_q - 32'h1;
    end
    else if (start_w)
    begin
      state_q   <= S_SEL;
      // Falling clock that ends the start is not a bit
      bit_q     <= 4'hf;
      drv_q     <= 1'b0;
      ack_q     <= 1'b0;
      wr_pend_q <= 1'b0;
      wr_any_q  <= 1'b0;
      pg_vld_q  <= {`EEP_PAGE_BYTES{1'b0}};
    end
    else if (stop_w)
    begin
      drv_q <= 1'b0;
      if (wr_pend_q & wr_any_q)
      begin
        state_q    <= S_PROG;
        prog_cnt_q <= WRITE_CYC - 32'h1;
        prog_idx_q <= 7'h0;
        prog_run_q <= 1'b1;
        if (idpg_q & lock_cmd_q)
          locked_q <= 1'b1;
      end
      else
        state_q <= S_IDLE;
      wr_pend_q <= 1'b0;
      wr_any_q  <= 1'b0;
    end
    else if (scl_rise & (state_q != S_IDLE))
    begin
      if (bit_q == 4'h8)
      begin
        if (state_q == S_RDAT)
          mack_q <= ~sda_w;
      end
      else if (state_q != S_RDAT)
        // Outgoing byte must not take in its own line echo
        sh_q <= byte_w;
      if (bit_q == 4'h7)
      begin
        ack_q <= 1'b0;
        case (state_q)
          S_SEL:
          begin
            if (sel_ok_w)
            begin
              ack_q  <= 1'b1;
              idpg_q <= byte_w[4];
            end
          end
          S_AHI:
            ack_q <= 1'b1;
          S_ALO:
            ack_q <= 1'b1;
          S_WDAT:
            // Protected or locked data is refused
            ack_q <= ~wp_w & ~(idpg_q & locked_q);
          default:
            ack_q <= 1'b0;
        endcase
      end
    end
    else if (scl_fall & (state_q != S_IDLE))
    begin
      drv_q <= 1'b0;
      if (bit_q == 4'h7)
      begin
        bit_q <= 4'h8;
        drv_q <= ack_q & (state_q != S_RDAT);
        if (state_q == S_SEL & ~ack_q)
          state_q <= S_IDLE;
        else if (state_q == S_WDAT & ack_q)
        begin
          pg_buf_q[addr_q[6:0]] <= sh_q;
          pg_vld_q[addr_q[6:0]] <= 1'b1;
          pg_base_q <= addr_q;
          wr_any_q  <= 1'b1;
          addr_q[6:0] <= addr_q[6:0] + 7'h01; // Roll over within page
        end
        else if (state_q == S_ALO)
          addr_q <= {addr_q[15:8], sh_q};
        else if (state_q == S_AHI)
        begin
          addr_q[15:8] <= sh_q;
          lock_cmd_q   <= sh_q[`EEP_LOCK_ADDR_BIT-8];
        end
      end
      else if (bit_q == 4'h8)
      begin
        bit_q <= 4'h0;
        case (state_q)
          S_SEL:
            if (sh_q[0])
            begin
              state_q   <= S_RDAT;
              drv_q     <= ~rd_byte_w[7];
              sh_q      <= {rd_byte_w[6:0], 1'b0};
            end
            else
              state_q <= S_AHI;
          S_AHI:
            state_q <= S_ALO;
          S_ALO:
          begin
            state_q   <= S_WDAT;
            wr_pend_q <= 1'b1;
          end
          S_WDAT:
            state_q <= S_WDAT;
          S_RDAT:
            if (mack_q)
            begin
              drv_q     <= ~rd_byte_w[7];
              sh_q      <= {rd_byte_w[6:0], 1'b0};
            end
            else
              state_q <= S_IDLE;
          default:
            state_q <= S_IDLE;
        endcase
      end
      else
      begin
        bit_q <= bit_q + 4'h1;
        if (state_q == S_RDAT)
        begin
          drv_q     <= ~sh_q[7];
          sh_q      <= {sh_q[6:0], 1'b0};
          if (bit_q == 4'h6)
            addr_q <= addr_q + 16'h0001;
        end
      end
    end
  end

  // Only ever pull low or release; never drives high
  assign sda_o    = 1'b0;
  assign sda_oe_o = drv_q;
  assign busy_o   = (state_q == S_PROG);
endmodule // eep_slave

// ### inc/eep_consts.vh
// Purpose: constants for the serial EEPROM bus slave front end
// Assumes: 10 MHz system clock
// Notes:   offsets, codes and timing counts as macros
`ifndef EEP_CONSTS_VH
`define EEP_CONSTS_VH
`define EEP_TYPE_MAIN      4'ha
`define EEP_TYPE_IDPG      4'hb
`define EEP_MAIN_AW        16
`define EEP_PAGE_BYTES     128
`define EEP_PAGE_COUNT     512
`define EEP_IDPG_AW        7
`define EEP_LOCK_ADDR_BIT  10
`define EEP_SYS_CLK_HZ     10000000
`define EEP_WRITE_MS       4
`define EEP_WRITE_CYC      (`EEP_WRITE_MS * (`EEP_SYS_CLK_HZ / 1000))
`endif

// ### verilog/eep_mem.v
// Purpose: byte memory with registered read data
// Assumes: single clock, one write or read per cycle
// Notes:   holds main array and identification page
module eep_mem #(
  parameter AW = 16
) (
  input  wire          sys_clk_i,
  input  wire          wr_en_i,
  input  wire [AW-1:0] addr_i,
  input  wire [7:0]    wr_data_i,
  output reg  [7:0]    rd_data_o
);
  reg [7:0] mem_q [0:(1<<AW)-1];
  always @(posedge sys_clk_i)
  begin
    if (wr_en_i)
      mem_q[addr_i] <= wr_data_i;
    rd_data_o <= mem_q[addr_i];
  end
endmodule // eep_mem

// ### verification/eep_slave_props.sv
// Purpose: port checks of the EEPROM bus slave
// Assumes: bus half period of 4 system clocks
// Notes:   bound to every eep_slave instance
module eep_slave_props #(
  parameter WRITE_CYC = 200
) (
  input logic sys_clk_i,
  input logic rst_i,
  input logic scl_i,
  input logic sda_i,
  input logic sda_o,
  input logic sda_oe_o,
  input logic busy_o
);
  logic [31:0] busy_cnt_q;
  always_ff @(posedge sys_clk_i or posedge rst_i)
    if (rst_i)
      busy_cnt_q <= '0;
    else
      busy_cnt_q <= busy_o ? busy_cnt_q + 32'h1 : '0;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  chk_od_low: assert property (sda_o == 1'b0)
    else $error("data pin value not low");
  chk_busy_silent: assert property (busy_o |-> !sda_oe_o)
    else $error("drive during write cycle");
  chk_rise_scl_low: assert property ($rose(sda_oe_o) |-> !scl_i)
    else $error("drive began with clock high");
  chk_fall_scl_low: assert property ($fell(sda_oe_o) |-> !scl_i)
    else $error("release with clock high");
  chk_busy_len: assert property ($fell(busy_o) |-> busy_cnt_q == WRITE_CYC)
    else $error("write cycle length wrong");
  chk_busy_at_stop: assert property ($rose(busy_o) |-> scl_i && sda_i)
    else $error("write cycle without stop");
  chk_reset_quiet: assert property ($fell(rst_i) |-> !sda_oe_o[*4])
    else $error("drive after reset");
  chk_start_silent: assert property (scl_i && $past(scl_i) && $fell(sda_i) |-> !sda_oe_o[*8])
    else $error("drive right after start");
endmodule // eep_slave_props

bind eep_slave eep_slave_props #(.WRITE_CYC(WRITE_CYC)) eep_slave_props_i (.sys_clk_i, .rst_i, .scl_i,
  .sda_i, .sda_o, .sda_oe_o, .busy_o);

// ### verification/eep_master_model.sv
// Purpose: bus master driving clock and data
// Assumes: data line pulled up outside
// Notes:   800 ns bit period; released line is 1
module eep_master_model (
  input  logic sys_clk_i,
  input  logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic clk(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  task automatic start();
    sda_o <= 1'b1;
    clk(4);
    scl_o <= 1'b1;
    clk(4);
    sda_o <= 1'b0;
    clk(4);
    scl_o <= 1'b0;
  endtask
  task automatic stop();
    clk(2);
    sda_o <= 1'b0;
    clk(2);
    scl_o <= 1'b1;
    clk(4);
    sda_o <= 1'b1;
    clk(4);
  endtask
  task automatic bit_x(input logic b, output logic r);
    clk(2);
    sda_o <= b;
    clk(2);
    scl_o <= 1'b1;
    clk(4);
    r = sda_i;
    scl_o <= 1'b0;
  endtask
  task automatic byte_w(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = !r;
  endtask
  task automatic byte_r(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    bit_x(last, r);
  endtask
endmodule // eep_master_model

// ### verification/test_eep_slave.sv
// Purpose: self-checking bench of the EEPROM slave
// Assumes: short write cycle of 200 clocks
// Notes:   straps fixed at zero outside select test
module test_eep_slave;
  timeunit 1ns;
  timeprecision 1ns;
  logic       sys_clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic [2:0] strap = 3'h0;
  logic       wp = 1'b0;
  logic       scl, m_sda, sda_o, sda_oe_o, busy_o;
  wire        sda_w = sda_oe_o ? sda_o : m_sda;
  int         error_cnt = 0;
  int         comparisons = 0;
  always #50 sys_clk_i = ~sys_clk_i;
  eep_slave #(.WRITE_CYC(200)) eep_slave_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .scl_i(scl),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .chip_select_strap_msb(strap[2]),
    .chip_select_strap_mid(strap[1]), .chip_select_strap_lsb(strap[0]), .write_protect_input(wp),
    .busy_o(busy_o));
  eep_master_model eep_master_model_i (.sys_clk_i(sys_clk_i), .sda_i(sda_w), .scl_o(scl), .sda_o(m_sda));
  task automatic end_sim();
    if (error_cnt == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk_ack(input string n, input logic e, input logic g);
    comparisons++;
    if (g !== e)
    begin
      $display("Error %s expected %b seen %b", n, e, g);
      error_cnt++;
    end
  endtask
  task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e)
    begin
      $display("Error %s expected %h seen %h", n, e, g);
      error_cnt++;
    end
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy_o !== 1'b0 && n < 400)
    begin
      @(posedge sys_clk_i);
      n++;
    end
    if (n == 400)
    begin
      error_cnt++;
      end_sim();
    end
  endtask
  task automatic sel(input logic [7:0] d, input logic e);
    logic a;
    eep_master_model_i.start();
    eep_master_model_i.byte_w(d, a);
    chk_ack("select", e, a);
  endtask
  task automatic wr(input logic [3:0] t, input logic [15:0] ad, input logic [7:0] d, input logic e);
    logic a;
    sel({t, 3'h0, 1'b0}, 1'b1);
    eep_master_model_i.byte_w(ad[15:8], a);
    chk_ack("addr hi", 1'b1, a);
    eep_master_model_i.byte_w(ad[7:0], a);
    chk_ack("addr lo", 1'b1, a);
    eep_master_model_i.byte_w(d, a);
    chk_ack("data", e, a);
  endtask
  task automatic rd(input logic [3:0] t, input logic [15:0] ad, input logic [7:0] e);
    logic [7:0] d;
    logic       a;
    sel({t, 3'h0, 1'b0}, 1'b1);
    eep_master_model_i.byte_w(ad[15:8], a);
    eep_master_model_i.byte_w(ad[7:0], a);
    sel({t, 3'h0, 1'b1}, 1'b1);
    eep_master_model_i.byte_r(1'b1, d);
    eep_master_model_i.stop();
    chk_byte("read", e, d);
  endtask
  task automatic s_select();
    @(posedge sys_clk_i);
    strap <= 3'h5;
    for (int i = 0; i < 24; i++)
    begin
      if (i < 16)
        sel({i[3:0], 3'h5, 1'b0}, i == 10 || i == 11);
      else
        sel({4'ha, i[2:0], 1'b0}, i == 21);
      eep_master_model_i.stop();
      wait_idle();
    end
    strap <= 3'h0;
  endtask
  task automatic s_page_write();
    logic       a;
    logic [7:0] d;
    wr(4'ha, 16'h107f, 8'h5a, 1'b1);
    eep_master_model_i.byte_w(8'ha5, a);
    chk_ack("data", 1'b1, a);
    eep_master_model_i.byte_w(8'hc3, a);
    chk_ack("data", 1'b1, a);
    eep_master_model_i.stop();
    repeat (8) @(posedge sys_clk_i);
    chk_ack("busy", 1'b1, busy_o);
    sel(8'ha0, 1'b0);
    eep_master_model_i.stop();
    wait_idle();
    rd(4'ha, 16'h107f, 8'h5a);
    rd(4'ha, 16'h1000, 8'ha5);
    sel(8'ha0, 1'b1);
    eep_master_model_i.byte_w(8'h10, a);
    eep_master_model_i.byte_w(8'h00, a);
    sel(8'ha1, 1'b1);
    eep_master_model_i.byte_r(1'b0, d);
    chk_byte("seq read 0", 8'ha5, d);
    eep_master_model_i.byte_r(1'b1, d);
    chk_byte("seq read 1", 8'hc3, d);
    eep_master_model_i.stop();
  endtask
  task automatic s_protect();
    wp <= 1'b1;
    wr(4'ha, 16'h107f, 8'h33, 1'b0);
    eep_master_model_i.stop();
    repeat (8) @(posedge sys_clk_i);
    chk_ack("busy", 1'b0, busy_o);
    rd(4'ha, 16'h107f, 8'h5a);
    wp <= 1'b0;
  endtask
  task automatic s_id_page();
    wr(4'hb, 16'h0003, 8'h3c, 1'b1);
    eep_master_model_i.stop();
    wait_idle();
    rd(4'hb, 16'h0003, 8'h3c);
    rd(4'hb, 16'h0400, 8'h00);
    wr(4'hb, 16'h0400, 8'h01, 1'b1);
    eep_master_model_i.stop();
    wait_idle();
    rd(4'hb, 16'h0400, 8'h01);
    wr(4'hb, 16'h0003, 8'hc3, 1'b0);
    eep_master_model_i.stop();
    rd(4'hb, 16'h0003, 8'h3c);
  endtask
  initial
  begin
    repeat (6) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    s_select();
    s_page_write();
    s_protect();
    s_id_page();
    end_sim();
  end
endmodule // test_eep_slave
